// File: logic/afc_pkg.sv
// Package for the automatic receive flow-control block: register layout,
// reset values and jam duration timing.
// Assumes a 200 MHz system clock and a plain register port.
package afc_pkg;
    // Register offset of the configuration register.
    localparam logic [7:0] CFG_OFFSET = 8'hac;
    localparam logic [7:0] STATUS_OFFSET = 8'hb4;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h00ff_ffff;
    // Field positions in the configuration register.
    localparam int HI_LSB = 16;
    localparam int LO_LSB = 8;
    localparam int DUR_LSB = 4;
    localparam int BIT_MULT = 3;
    localparam int BIT_BRD = 2;
    localparam int BIT_ADDR = 1;
    localparam int BIT_ANY = 0;
    // FIFO occupancy width in bytes and threshold unit (64 bytes, shift 6).
    localparam int LEVEL_W = 14;
    localparam int UNIT_SHIFT = 6;
    // Clock rate and jam durations.
    localparam int CLK_MHZ = 200;
    localparam int DUR_BASE_NS = 50000;
    localparam int DUR_SHORT0_NS = 5000;
    localparam int DUR_SHORT1_NS = 10000;
    localparam int DUR_SHORT2_NS = 15000;
    localparam int DUR_SHORT3_NS = 25000;
    localparam int DUR_10M_EXTRA_NS = 2200;
    localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;
    localparam int CYC_EXTRA_10M = (DUR_10M_EXTRA_NS * 1000) / CLK_PERIOD_PS;
    localparam int CNT_W = 18;
    // Controller states.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_JAM
    } jam_state_t;
endpackage : afc_pkg

// File: logic/jam_timer.sv
// Jam duration timer: loads a cycle count from the duration code and link
// speed, then counts down to zero.
// Assumes the start pulse comes from logic on the same clock.
`timescale 1ns/1ps
module jam_timer
    import afc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Control.
    input wire logic start_i,
    input wire logic [3:0] code_i,
    input wire logic speed_100_i,
    // Status.
    output logic busy_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } timer_t;

    timer_t state_reg;
    timer_t state_next;

    // Converts a duration code to cycles; codes 4h and up grow by 50 us steps.
    function automatic logic [CNT_W-1:0] dur_cycles(input logic [3:0] code, input logic fast);
        int ns;
        ns = 0;
        case (code)
            4'h0: ns = DUR_SHORT0_NS;
            4'h1: ns = DUR_SHORT1_NS;
            4'h2: ns = DUR_SHORT2_NS;
            4'h3: ns = DUR_SHORT3_NS;
            default: ns = DUR_BASE_NS * (int'(code) - 3);
        endcase
        dur_cycles = CNT_W'((ns * 1000) / CLK_PERIOD_PS + (fast ? 0 : CYC_EXTRA_10M));
    endfunction : dur_cycles

    // Load on start, otherwise count down to zero.
    always_comb begin
        state_next = state_reg;
        if (start_i) begin
            state_next.cnt = dur_cycles(code_i, speed_100_i);
        end else if (state_reg.cnt != '0) begin
            state_next.cnt = state_reg.cnt - CNT_W'(1);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign busy_o = (state_reg.cnt != '0);
endmodule : jam_timer

// File: logic/rx_fifo_auto_flow_control.sv
// Automatic receive flow control: compares receive FIFO occupancy with
// programmed thresholds, jams frames in half duplex, requests pause frames
// in full duplex.
// Assumes the MAC, FIFO and receive front end share the 200 MHz clock.
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module rx_fifo_auto_flow_control
    import afc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Link mode and transmitter state.
    input wire logic full_duplex_i,
    input wire logic speed_100_i,
    input wire logic tx_enable_i,
    // Receive FIFO occupancy in bytes.
    input wire logic [LEVEL_W-1:0] fifo_level_i,
    // Receive front end events, one-cycle pulses.
    input wire logic rx_preamble_i,
    input wire logic rx_addr_valid_i,
    input wire logic rx_multicast_i,
    input wire logic rx_broadcast_i,
    input wire logic rx_own_addr_i,
    // Pause request toward the MAC.
    output logic pause_req_o,
    output logic pause_zero_o,
    input wire logic pause_sent_i,
    // Back pressure toward the MAC.
    output logic jam_o
);
    typedef struct packed {
        logic [31:0] cfg;
        logic [31:0] rdata;
        logic paused;
        logic pend;
        logic pend_zero;
        logic above_d;
        jam_state_t jst;
    } state_t;

    state_t state_reg;
    state_t state_next;
    logic timer_busy;
    logic jam_start;
    logic [LEVEL_W-1:0] hi_bytes;
    logic [LEVEL_W-1:0] lo_bytes;
    logic above_hi;
    logic below_lo;
    logic any_en;
    logic hd_match;

    // Scales an 8-bit threshold in 64-byte units to a byte count.
    function automatic logic [LEVEL_W-1:0] to_bytes(input logic [7:0] units);
        to_bytes = LEVEL_W'({units, 6'h00});
    endfunction : to_bytes

    // Live level comparisons against the programmed thresholds.
    assign hi_bytes = to_bytes(state_reg.cfg[HI_LSB +: 8]);
    assign lo_bytes = to_bytes(state_reg.cfg[LO_LSB +: 8]);
    assign above_hi = (fifo_level_i >= hi_bytes);
    assign below_lo = (fifo_level_i < lo_bytes);
    assign any_en = state_reg.cfg[BIT_ANY];

    // Half-duplex match: any-frame acts on preamble and overrides the others.
    always_comb begin
        if (any_en) begin
            hd_match = rx_preamble_i;
        end else begin
            hd_match = rx_addr_valid_i &&
                ((state_reg.cfg[BIT_MULT] && rx_multicast_i) ||
                 (state_reg.cfg[BIT_BRD] && rx_broadcast_i) ||
                 (state_reg.cfg[BIT_ADDR] && rx_own_addr_i));
        end
    end

    // Register access and flow-control sequencing.
    always_comb begin
        state_next = state_reg;
        jam_start = 1'b0;
        state_next.above_d = above_hi;
        // Register writes; reserved bits stay zero.
        if (reg_wr_i && reg_addr_i == CFG_OFFSET) begin
            state_next.cfg = reg_wdata_i & CFG_WRITE_MASK;
        end
        // Read data appears the cycle after the strobe.
        state_next.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                CFG_OFFSET: state_next.rdata = state_reg.cfg;
                STATUS_OFFSET: state_next.rdata = {27'h0, jam_o, state_reg.pend_zero,
                    state_reg.pend, state_reg.paused, above_hi};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        // A sent pause retires the pending request; new requests may follow.
        if (pause_sent_i && state_reg.pend) begin
            state_next.pend = 1'b0;
        end
        // Full duplex: one pause on rising across the high level.
        if (full_duplex_i && any_en && tx_enable_i) begin
            if (above_hi && !state_reg.above_d && !state_reg.paused) begin
                state_next.pend = 1'b1;
                state_next.pend_zero = 1'b0;
                state_next.paused = 1'b1;
            end else if (state_reg.paused && below_lo) begin
                state_next.pend = 1'b1;
                state_next.pend_zero = 1'b1;
                state_next.paused = 1'b0;
            end
        end else if (!any_en) begin
            state_next.paused = 1'b0;
        end
        // Half duplex jam state machine.
        case (state_reg.jst)
            ST_IDLE: begin
                if (!full_duplex_i && tx_enable_i && above_hi && hd_match) begin
                    jam_start = 1'b1;
                    state_next.jst = ST_JAM;
                end
            end
            ST_JAM: begin
                if (!timer_busy && !jam_start) begin
                    state_next.jst = ST_IDLE;
                end
            end
            default: state_next.jst = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= '{cfg: CFG_RESET, rdata: 32'h0000_0000, paused: 1'b0,
                pend: 1'b0, pend_zero: 1'b0, above_d: 1'b0, jst: ST_IDLE};
        end else begin
            state_reg <= state_next;
        end
    end

    // Duration timer, loaded at the start of each jam.
    jam_timer u_timer (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .start_i(jam_start),
        .code_i(state_reg.cfg[DUR_LSB +: 4]),
        .speed_100_i(speed_100_i),
        .busy_o(timer_busy)
    );

    // Outputs; the jam is held while the timer runs.
    assign jam_o = timer_busy;
    assign pause_req_o = state_reg.pend;
    assign pause_zero_o = state_reg.pend_zero;
    assign reg_rdata_o = state_reg.rdata;
endmodule : rx_fifo_auto_flow_control

// File: sim/afc_monitor.sv
// Port checker for the automatic flow-control block.
// Assumes it is bound to the top module and sees every register write.
`timescale 1ns/1ps
module afc_monitor
    import afc_pkg::*;
(
    // Clock, reset and register port.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    // Link and receive events.
    input wire logic full_duplex_i,
    input wire logic speed_100_i,
    input wire logic tx_enable_i,
    input wire logic [LEVEL_W-1:0] fifo_level_i,
    input wire logic rx_preamble_i,
    input wire logic rx_addr_valid_i,
    // MAC side.
    input wire logic pause_req_o,
    input wire logic pause_zero_o,
    input wire logic pause_sent_i,
    input wire logic jam_o
);
    logic [31:0] cfg_reg;
    logic [17:0] len_reg;
    logic [13:0] hi_lvl;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    assign hi_lvl = {cfg_reg[23:16], 6'h0};
    // Jam length in cycles; 10 Mb/s adds 440 cycles of 5 ns.
    function automatic int jam_cyc(logic [3:0] c, logic fast);
        int t;
        t = (c < 4) ? ((c == 3) ? 5000 : 1000 * (c + 1)) : 10000 * (c - 3);
        return fast ? t : t + 440;
    endfunction : jam_cyc
    // Shadow of the configuration word and length of the current jam.
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) cfg_reg <= 32'h0;
        else if (reg_wr_i && reg_addr_i == CFG_OFFSET) cfg_reg <= reg_wdata_i & CFG_WRITE_MASK;
        len_reg <= (jam_o && rst_n_i) ? len_reg + 18'h1 : 18'h0;
    end
    property p_fd; $rose(pause_req_o) |-> $past(cfg_reg[0] & full_duplex_i); endproperty
    a_fd: assert property (p_fd) else $error("pause outside full duplex any mode");
    property p_tx; $rose(pause_req_o) |-> $past(tx_enable_i); endproperty
    a_tx: assert property (p_tx) else $error("pause with transmitter off");
    property p_hold; pause_req_o && !pause_sent_i |=> pause_req_o; endproperty
    a_hold: assert property (p_hold) else $error("pause request dropped early");
    property p_hi; $rose(pause_req_o) && !pause_zero_o |-> $past(fifo_level_i) >= hi_lvl; endproperty
    a_hi: assert property (p_hi) else $error("pause below high level");
    property p_lo; $rose(pause_req_o) && pause_zero_o |->
        $past(fifo_level_i) < {cfg_reg[15:8], 6'h0}; endproperty
    a_lo: assert property (p_lo) else $error("zero pause above low level");
    // The timer loads at the matching edge, so jam_o rises one cycle after the match.
    property p_hd; $rose(jam_o) |-> !$past(full_duplex_i); endproperty
    a_hd: assert property (p_hd) else $error("jam in full duplex");
    property p_any; $rose(jam_o) && cfg_reg[0] |-> $past(rx_preamble_i); endproperty
    a_any: assert property (p_any) else $error("jam without preamble");
    property p_typ; $rose(jam_o) && !cfg_reg[0] |-> $past(rx_addr_valid_i); endproperty
    a_typ: assert property (p_typ) else $error("jam without address match");
    property p_lvl; $rose(jam_o) |-> $past(fifo_level_i) >= hi_lvl; endproperty
    a_lvl: assert property (p_lvl) else $error("jam below high level");
    property p_len; $fell(jam_o) |-> len_reg == jam_cyc(cfg_reg[7:4], speed_100_i); endproperty
    a_len: assert property (p_len) else $error("jam length wrong");
endmodule : afc_monitor
bind rx_fifo_auto_flow_control afc_monitor u_mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .full_duplex_i(full_duplex_i), .speed_100_i(speed_100_i), .tx_enable_i(tx_enable_i),
    .fifo_level_i(fifo_level_i), .rx_preamble_i(rx_preamble_i),
    .rx_addr_valid_i(rx_addr_valid_i), .pause_req_o(pause_req_o),
    .pause_zero_o(pause_zero_o), .pause_sent_i(pause_sent_i), .jam_o(jam_o));

// File: sim/mac_pause_model.sv
// MAC transmit model: sends a pending pause frame after a delay.
// Assumes the request is a level that holds until answered.
`timescale 1ns/1ps
module mac_pause_model #(parameter int DELAY = 20) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Pause handshake.
    input wire logic pause_req_i,
    output logic pause_sent_o = 1'b0
);
    int cnt = 0;
    // The wait stands for a frame in flight, which is cut short if the request falls.
    always @(posedge mclk_i) begin
        pause_sent_o <= 1'b0;
        if (!rst_n_i || !pause_req_i || pause_sent_o) cnt <= 0;
        else if (cnt == DELAY) pause_sent_o <= 1'b1;
        else cnt <= cnt + 1;
    end
endmodule : mac_pause_model

// File: sim/rx_fifo_auto_flow_control_tb.sv
// Bench for the flow-control block with a MAC pause model.
// Assumes a 200 MHz clock and no other driver of the ports.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module rx_fifo_auto_flow_control_tb;
    import afc_pkg::*;
    logic mclk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0;
    logic fd = 1'b0, sp = 1'b1, pre = 1'b0, av = 1'b0, mc = 1'b0, bc = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [LEVEL_W-1:0] lvl = '0;
    logic req, zero, sent, jam;
    int n_errors = 0, total_checks = 0, n;
    // Free-running system clock.
    always #2.5 mclk_i = ~mclk_i;
    rx_fifo_auto_flow_control DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .full_duplex_i(fd), .speed_100_i(sp), .tx_enable_i(1'b1), .fifo_level_i(lvl),
        .rx_preamble_i(pre), .rx_addr_valid_i(av), .rx_multicast_i(mc), .rx_broadcast_i(bc),
        .rx_own_addr_i(1'b0), .pause_req_o(req), .pause_zero_o(zero), .pause_sent_i(sent),
        .jam_o(jam));
    mac_pause_model u_mac (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pause_req_i(req),
        .pause_sent_o(sent));
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1 `CHK(rdata, e)
        @(posedge mclk_i);
    endtask : rd_chk
    // One frame in half duplex, then the jam length in cycles.
    task automatic jam_len(input logic [3:0] c, input logic s, input logic a, input int e);
        wr_reg(CFG_OFFSET, {8'h0, 8'h02, 8'h01, c, 3'b100, a});
        sp <= s;
        pre <= a;
        av <= !a;
        mc <= !a;
        @(posedge mclk_i);
        {pre, av, mc} <= 3'b000;
        n = 0;
        // Jam rises at the match edge; count from the first negedge after it.
        @(negedge mclk_i);
        while (jam === 1'b1 && n < 20000) begin
            n++;
            @(negedge mclk_i);
        end
        `CHK(n, e)
        @(posedge mclk_i);
    endtask : jam_len
    // The whole run needs about 20000 cycles.
    initial begin
        #250000 n_errors++;
        wrap_up();
    end
    // Registers, then full duplex pause, then half duplex jam.
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd_chk(CFG_OFFSET, CFG_RESET);
        rd_chk(8'h10, 32'h0);
        wr_reg(CFG_OFFSET, 32'hffff_ffff);
        rd_chk(CFG_OFFSET, CFG_WRITE_MASK);
        fd <= 1'b1;
        wr_reg(CFG_OFFSET, 32'h0002_0101);
        lvl <= 14'd200;
        @(posedge mclk_i);
        @(negedge mclk_i);
        `CHK({req, zero}, 2'b10)
        repeat (60) @(negedge mclk_i);
        `CHK(req, 1'b0)
        @(posedge mclk_i);
        lvl <= 14'd10;
        @(posedge mclk_i);
        @(negedge mclk_i);
        `CHK({req, zero}, 2'b11)
        repeat (60) @(posedge mclk_i);
        wr_reg(CFG_OFFSET, 32'h0002_0108);
        lvl <= 14'd200;
        repeat (10) @(negedge mclk_i);
        `CHK(req, 1'b0)
        @(posedge mclk_i);
        fd <= 1'b0;
        jam_len(4'h0, 1'b1, 1'b1, 1000);
        jam_len(4'h3, 1'b1, 1'b0, 5000);
        jam_len(4'h4, 1'b1, 1'b1, 10000);
        jam_len(4'h0, 1'b0, 1'b1, 1440);
        jam_len(4'h1, 1'b0, 1'b0, 2440);
        {av, bc} <= 2'b11;
        @(posedge mclk_i);
        {av, bc} <= 2'b00;
        repeat (5) @(negedge mclk_i);
        `CHK(jam, 1'b0)
        wrap_up();
    end
endmodule : rx_fifo_auto_flow_control_tb
